// [core/pio_ctl_pkg.sv]
/*
  Constants for the port control-word programming block: control word codes,
  field positions, reset values and the return opcode bytes.
  Assumes a single 125 MHz clock and synchronous bus inputs.
*/
// What this block does
// - At most four devices on one priority chain without look-ahead logic.
// - Priority enable status is held constant while opcode-fetch strobe is active; the code still updates it at the first clock edge of the fetch.
// - Interrupt control without mask enables interrupts at first non-acknowledge fetch end.
// - With a mask, interrupts enable at the first non-acknowledge fetch end after the mask.
// - Low nibble all ones selects mode from bits 7:6; bits 5:4 ignored.
// - After bit-control mode is selected the next control word is the direction word.
// - Direction bit one makes the line an input, zero an output.
// - Control word with bit 0 low stores bits 7:1 as interrupt vector.
// - Low nibble 0111: bit7 enable, bit6 logic, bit5 polarity, bit4 mask follows.
// - When mask-follows is set the next control word is the mask.
// - Mask zero includes a line in the logic function, one excludes it.
// - Bit-control logic also evaluates unmasked output lines from the output register.
// - OR logic with active-high polarity requests when any monitored line is high.
// - A separate command sets or clears only the interrupt enable flip-flop; the code also clears a pending armed enable.
// - Port select and control/data select address four data and control locations.
// - After acknowledge priority enable out stays low until return decoded with enable in high.
// - Bit-control requests only on a false-to-true change of the logic result.
// - No new request is created while the opcode-fetch strobe is active.
package pio_ctl_pkg;
  localparam logic [3:0] MODE_NIBBLE   = 4'hF;
  localparam logic [3:0] ICW_NIBBLE    = 4'h7;
  localparam logic [3:0] IEN_NIBBLE    = 4'h3;
  localparam int         VEC_FLAG_BIT  = 0;
  localparam int         MODE_HI_BIT   = 7;
  localparam int         ICW_EN_BIT    = 7;
  localparam int         ICW_AND_BIT   = 6;
  localparam int         ICW_HIGH_BIT  = 5;
  localparam int         ICW_MASK_BIT  = 4;
  localparam logic [1:0] MODE_OUTPUT   = 2'h0;
  localparam logic [1:0] MODE_INPUT    = 2'h1;
  localparam logic [1:0] MODE_BIDIR    = 2'h2;
  localparam logic [1:0] MODE_BITCTL   = 2'h3;
  localparam logic [1:0] MODE_RESET    = 2'h1;
  localparam logic [7:0] DIR_RESET     = 8'hFF;
  localparam logic [7:0] MASK_RESET    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [6:0] VEC_RESET     = 7'h00;
  localparam logic [7:0] RETURN_FROM_INTERRUPT_OPCODE_PREFIX   = 8'hED;
  localparam logic [7:0] RETURN_FROM_INTERRUPT_OPCODE_SECOND   = 8'h4D;
  localparam int         CHAIN_MAX     = 4;
  typedef enum logic [2:0] {
    WORD_ANY  = 3'b001,
    WORD_DIR  = 3'b010,
    WORD_MASK = 3'b100
  } expect_e;
endpackage : pio_ctl_pkg

// [core/pio_port_ctl.sv]
/*
  One port's control-word programming, bit-control interrupt logic and
  daisy-chain priority handling.
  Assumes bus strobes are synchronous to CLOCK and active low; the other
  port and any other chain members sit outside.
  Assumes the host holds each write for exactly one clock, sends the
  direction or mask word straight after the word that announces it, and
  reads a return opcode as two fetches in a row.
*/
`timescale 1ns/1ps
`default_nettype none
module pio_port_ctl #(
  parameter logic PORT_SEL_ID = 1'b0
) (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       ARST_N,
  // cpu bus
  input  wire logic       CE_N,
  input  wire logic       PORT_SEL,
  input  wire logic       CTRL_SEL,
  input  wire logic       IO_REQUEST_STROBE_N,
  input  wire logic       RD_N,
  input  wire logic       OPCODE_FETCH_STROBE_N,
  input  wire logic [7:0] DATA_IN,
  // vector readback
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_N,
  // port lines
  input  wire logic [7:0] PORT_IN,
  output logic      [7:0] PORT_OUT,
  output logic      [7:0] PORT_DIR,
  output logic      [1:0] PORT_MODE,
  // interrupt chain
  input  wire logic       PRIORITY_ENABLE_IN,
  output logic            PRIORITY_ENABLE_OUT,
  output logic            INT_REQ_N,
  output logic            INT_ENABLED
);

  // bus decode
  wire sel_w      = !CE_N && !IO_REQUEST_STROBE_N && OPCODE_FETCH_STROBE_N && (PORT_SEL == PORT_SEL_ID);
  wire wr_w       = sel_w && RD_N;
  wire ctl_wr_w   = wr_w && CTRL_SEL;
  wire data_wr_w  = wr_w && !CTRL_SEL;
  wire fetch_w    = !OPCODE_FETCH_STROBE_N;
  wire ack_w      = fetch_w && !IO_REQUEST_STROBE_N;

  logic             fetch_r;
  logic             ack_seen_r;
  pio_ctl_pkg::expect_e expect_r;
  logic [1:0]       mode_r;
  logic [7:0]       dir_r;
  logic [7:0]       mask_r;
  logic [7:0]       out_r;
  logic [6:0]       vec_r;
  logic             ien_r;
  logic             arm_r;
  logic             and_r;
  logic             high_r;
  logic             logic_r;
  logic             pend_r;
  logic             serv_r;
  logic             ed_r;
  logic             ieo_r;
  logic             fetch_end_w;
  logic             oe_r;
  logic             aux_r;

  // control word classification
  wire is_dir_w   = ctl_wr_w && expect_r == pio_ctl_pkg::WORD_DIR;
  wire is_mask_w  = ctl_wr_w && expect_r == pio_ctl_pkg::WORD_MASK;
  wire plain_w    = ctl_wr_w && expect_r == pio_ctl_pkg::WORD_ANY;
  wire is_vec_w   = plain_w && !DATA_IN[pio_ctl_pkg::VEC_FLAG_BIT];
  wire is_mode_w  = plain_w && DATA_IN[3:0] == pio_ctl_pkg::MODE_NIBBLE;
  wire is_icw_w   = plain_w && DATA_IN[3:0] == pio_ctl_pkg::ICW_NIBBLE;
  wire is_ien_w   = plain_w && DATA_IN[3:0] == pio_ctl_pkg::IEN_NIBBLE;
  wire [1:0] new_mode_w = DATA_IN[pio_ctl_pkg::MODE_HI_BIT -: 2];

  // bit-control logic function over input pins and output register
  wire [7:0] line_w   = (PORT_IN & dir_r) | (out_r & ~dir_r);
  wire [7:0] act_w    = high_r ? line_w : ~line_w;
  wire       or_w     = |(act_w & ~mask_r);
  wire       and_w    = (mask_r != 8'hFF) && &(act_w | mask_r);
  wire       result_w = (mode_r == pio_ctl_pkg::MODE_BITCTL) && (and_r ? and_w : or_w);
  wire       rise_w   = result_w && !logic_r && !fetch_w;
  assign fetch_end_w  = fetch_r && !fetch_w;

  // expected next control word
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      expect_r <= pio_ctl_pkg::WORD_ANY;
    end else if (is_mode_w && new_mode_w == pio_ctl_pkg::MODE_BITCTL) begin
      expect_r <= pio_ctl_pkg::WORD_DIR;
    end else if (is_icw_w && DATA_IN[pio_ctl_pkg::ICW_MASK_BIT]) begin
      expect_r <= pio_ctl_pkg::WORD_MASK;
    end else if (is_dir_w || is_mask_w) begin
      expect_r <= pio_ctl_pkg::WORD_ANY;
    end
  end

  // mode, direction, mask, vector and output data
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_r <= pio_ctl_pkg::MODE_RESET;
      dir_r  <= pio_ctl_pkg::DIR_RESET;
      mask_r <= pio_ctl_pkg::MASK_RESET;
      out_r  <= pio_ctl_pkg::BYTE_ZERO;
      vec_r  <= pio_ctl_pkg::VEC_RESET;
      and_r  <= 1'b0;
      high_r <= 1'b0;
    end else begin
      if (is_mode_w) mode_r <= new_mode_w;
      if (is_dir_w) dir_r <= DATA_IN;
      if (is_mask_w) mask_r <= DATA_IN;
      if (data_wr_w) out_r <= DATA_IN;
      if (is_vec_w) vec_r <= DATA_IN[7:1];
      if (is_icw_w) begin
        and_r  <= DATA_IN[pio_ctl_pkg::ICW_AND_BIT];
        high_r <= DATA_IN[pio_ctl_pkg::ICW_HIGH_BIT];
      end
    end
  end

  // interrupt enable: armed by a write, taken at the end of a fetch strobe
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ien_r      <= 1'b0;
      arm_r      <= 1'b0;
      aux_r      <= 1'b0;
      fetch_r    <= 1'b0;
      ack_seen_r <= 1'b0;
    end else begin
      fetch_r <= fetch_w;
      if (fetch_end_w) ack_seen_r <= 1'b0;
      else if (ack_w) ack_seen_r <= 1'b1;
      if (is_icw_w) begin
        ien_r <= 1'b0;
        aux_r <= DATA_IN[pio_ctl_pkg::ICW_EN_BIT];
        arm_r <= !DATA_IN[pio_ctl_pkg::ICW_MASK_BIT];
      end else if (is_mask_w) begin
        arm_r <= 1'b1;
      end else if (is_ien_w) begin
        ien_r <= DATA_IN[pio_ctl_pkg::ICW_EN_BIT];
        arm_r <= 1'b0;
      end else if (fetch_end_w && arm_r && !ack_seen_r) begin
        ien_r <= aux_r;
        arm_r <= 1'b0;
      end
    end
  end

  // acknowledge that picks this port, and the second byte of a return opcode
  // ed_cur_r gathers the prefix within one fetch; ed_r carries it into the next
  logic             ed_cur_r;
  wire ack_hit_w  = ack_w && pend_r && PRIORITY_ENABLE_IN;
  wire return_from_interrupt_opcode_w     = fetch_w && IO_REQUEST_STROBE_N && !RD_N && ed_r && PRIORITY_ENABLE_IN
                    && DATA_IN == pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_SECOND;

  // logic result is sampled only outside a fetch
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      logic_r <= 1'b0;
    end else if (!fetch_w) begin
      logic_r <= result_w;
    end
  end

  // pending request: set on a false-to-true change, cleared by our acknowledge
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend_r <= 1'b0;
    end else if (ack_hit_w) begin
      pend_r <= 1'b0;
    end else if (rise_w && ien_r) begin
      pend_r <= 1'b1;
    end
  end

  // under service from our acknowledge until the return opcode
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      serv_r <= 1'b0;
    end else if (ack_hit_w) begin
      serv_r <= 1'b1;
    end else if (return_from_interrupt_opcode_w) begin
      serv_r <= 1'b0;
    end
  end

  // return prefix: a flag cleared at each fetch end would never reach the second byte
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ed_r     <= 1'b0;
      ed_cur_r <= 1'b0;
    end else if (fetch_end_w) begin
      ed_r     <= ed_cur_r;
      ed_cur_r <= 1'b0;
    end else if (fetch_w && !RD_N && DATA_IN == pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_PREFIX) begin
      ed_cur_r <= 1'b1;
    end
  end

  // chain output, updated only outside a fetch or in its first cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ieo_r <= 1'b1;
    end else if (!fetch_w || !fetch_r) begin
      ieo_r <= PRIORITY_ENABLE_IN && !serv_r && !(pend_r && !ed_r);
    end
  end

  // vector drive for one cycle after our acknowledge
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= ack_hit_w;
    end
  end

  // outputs straight from flops
  assign DATA_OUT            = {vec_r, 1'b0};
  assign DATA_OE_N           = !oe_r;
  assign PORT_OUT            = out_r;
  assign PORT_DIR            = dir_r;
  assign PORT_MODE           = mode_r;
  assign PRIORITY_ENABLE_OUT = ieo_r;
  assign INT_REQ_N           = !pend_r;
  assign INT_ENABLED         = ien_r;

  // enable becomes set only at a fetch strobe end or direct command
  ien_rise_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(ien_r) |-> $past(fetch_end_w) || $past(is_ien_w)) else $error("enable rose off a fetch end");

  // no enable at an acknowledge fetch end
  ack_noen_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_end_w && ack_seen_r && !is_ien_w && !is_icw_w |=> $stable(ien_r)) else $error("enable on acknowledge");

  // mask write arms the enable
  mask_arm_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_mask_w |=> arm_r) else $error("mask did not arm");

  // bit-control selection expects the direction word
  dir_next_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_mode_w && new_mode_w == pio_ctl_pkg::MODE_BITCTL |=> expect_r == pio_ctl_pkg::WORD_DIR) else $error("no dir");

  // direction word is taken verbatim
  dir_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_dir_w |=> PORT_DIR == $past(DATA_IN)) else $error("direction not loaded");

  // vector keeps bits 7:1
  vec_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_vec_w |=> DATA_OUT[7:1] == $past(DATA_IN[7:1])) else $error("vector not loaded");

  // no request raised during fetch strobe
  fetch_noreq_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_w && !ack_w |=> !$fell(INT_REQ_N)) else $error("request during fetch");

  // chain output frozen through a fetch
  chain_hold_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_r && fetch_w |=> $stable(ieo_r)) else $error("chain moved in fetch");

  // enable command changes only the enable and arm flops
  ien_cmd_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_ien_w |=> ien_r == $past(DATA_IN[7]) && $stable(and_r) && $stable(high_r)) else $error("bad cmd");

  // a port under service blocks the chain
  serv_hold_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    serv_r && !fetch_w |=> !PRIORITY_ENABLE_OUT) else $error("chain open in service");

  // mask word is taken verbatim
  mask_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_mask_w |=> mask_r == $past(DATA_IN)) else $error("mask not loaded");

  // mode word loads bits 7:6
  mode_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_mode_w |=> PORT_MODE == $past(new_mode_w)) else $error("mode not loaded");

  // other modes leave the word decode free
  mode_any_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_mode_w && new_mode_w != pio_ctl_pkg::MODE_BITCTL |=> expect_r == pio_ctl_pkg::WORD_ANY) else $error("mode stuck");

  // mask-follows bit expects the mask word
  mask_next_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_icw_w && DATA_IN[pio_ctl_pkg::ICW_MASK_BIT] |=> expect_r == pio_ctl_pkg::WORD_MASK) else $error("no mask");

  // direction or mask word ends the sequence
  dir_done_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_dir_w || is_mask_w |=> expect_r == pio_ctl_pkg::WORD_ANY) else $error("sequence stuck");

  // logic and polarity fields follow the control word
  icw_fields_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_icw_w |=> and_r == $past(DATA_IN[6]) && high_r == $past(DATA_IN[5])) else $error("fields not loaded");

  // an enabled rise raises the request
  rise_req_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    rise_w && ien_r |=> !INT_REQ_N) else $error("rise missed");

  // nothing but an enabled rise raises the request
  level_noreq_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !(rise_w && ien_r) && INT_REQ_N |=> INT_REQ_N) else $error("request without rise");

  // a request stands until acknowledged
  req_stand_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !INT_REQ_N && !ack_hit_w |=> !INT_REQ_N) else $error("request dropped");

  // our acknowledge drives the vector
  vec_drive_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ack_hit_w |=> !DATA_OE_N) else $error("vector not driven");

  // the vector is driven for one cycle only
  oe_once_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !DATA_OE_N |=> DATA_OE_N) else $error("vector held");

  // our acknowledge starts service and drops the request
  ack_serv_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ack_hit_w |=> serv_r && INT_REQ_N) else $error("ack not served");

  // return opcode ends service
  return_from_interrupt_opcode_clear_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    return_from_interrupt_opcode_w |=> !serv_r) else $error("return missed");

  // a fetched prefix is carried into the next fetch
  ed_carry_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_end_w |=> ed_r == $past(ed_cur_r)) else $error("prefix lost");

  // data write loads the output register
  out_load_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    data_wr_w |=> PORT_OUT == $past(DATA_IN)) else $error("output not loaded");

  // a blocked chain input blocks the output
  chain_block_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !PRIORITY_ENABLE_IN && !fetch_w |=> !PRIORITY_ENABLE_OUT) else $error("chain not blocked");

  // armed fetch end takes the stored enable
  arm_en_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_end_w && arm_r && !ack_seen_r && !ctl_wr_w |=> ien_r == $past(aux_r)) else $error("enable not taken");

  // enable command leaves the other settings alone
  ien_keep_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    is_ien_w |=> $stable(mask_r) && $stable(mode_r) && $stable(dir_r)) else $error("cmd touched setup");

endmodule : pio_port_ctl
`default_nettype wire

// [testbench/host_bus_model.sv]
/*
  Host cpu bus model: write cycles, opcode fetches and interrupt acknowledge.
  Assumes a free running clock; the bench calls the tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // clock and device readback
  input  wire logic       clock,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  // cpu bus
  output logic            ce_n,
  output logic            port_sel,
  output logic            ctrl_sel,
  output logic            io_req_n,
  output logic            rd_n,
  output logic            fetch_n,
  output logic      [7:0] data_in
);
  // idle bus at time zero
  initial begin
    ce_n     = 1'b1;
    port_sel = 1'b0;
    ctrl_sel = 1'b0;
    io_req_n = 1'b1;
    rd_n     = 1'b1;
    fetch_n  = 1'b1;
    data_in  = 8'h00;
  end
  // one write, held across exactly one sampling edge; released data is inverted
  task automatic wr(input logic ps, input logic cs, input logic [7:0] d);
    @(negedge clock);
    {ce_n, io_req_n, port_sel, ctrl_sel, data_in} = {2'b00, ps, cs, d};
    @(negedge clock);
    {ce_n, io_req_n, data_in} = {2'b11, ~d};
  endtask : wr
  // opcode fetch lasting n cycles
  task automatic fetch(input logic [7:0] d, input int n);
    @(negedge clock);
    {fetch_n, rd_n, data_in} = {2'b00, d};
    repeat (n) @(negedge clock);
    {fetch_n, rd_n, data_in} = {2'b11, ~d};
  endtask : fetch
  // interrupt acknowledge: fetch and io request together, vector captured where it is settled
  task automatic ack(output logic seen, output logic [7:0] v);
    seen = 1'b0;
    v = 8'h00;
    @(negedge clock);
    {fetch_n, io_req_n} = 2'b00;
    repeat (3) begin
      @(negedge clock);
      if (data_oe_n === 1'b0) begin
        seen = 1'b1;
        v = data_out;
      end
    end
    {fetch_n, io_req_n} = 2'b11;
  endtask : ack
endmodule : host_bus_model
`default_nettype wire

// [testbench/tb_top.sv]
/*
  Self-checking bench for one port's control programming and interrupt logic.
  Assumes the host bus model drives the cpu side; this bench drives the port lines.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic       clock, arst_n, ce_n, port_sel, ctrl_sel, io_req_n, rd_n, fetch_n, prio_in;
  logic       data_oe_n, prio_out, int_req_n, int_en, seen;
  logic [7:0] data_in, data_out, port_in, port_out, port_dir, v;
  logic [1:0] port_mode;
  int         error_cnt, check_count;
  // design and host
  pio_port_ctl #(.PORT_SEL_ID(1'b0)) u_dut (.CLOCK(clock), .ARST_N(arst_n), .CE_N(ce_n),
    .PORT_SEL(port_sel), .CTRL_SEL(ctrl_sel), .IO_REQUEST_STROBE_N(io_req_n), .RD_N(rd_n),
    .OPCODE_FETCH_STROBE_N(fetch_n), .DATA_IN(data_in), .DATA_OUT(data_out),
    .DATA_OE_N(data_oe_n), .PORT_IN(port_in), .PORT_OUT(port_out), .PORT_DIR(port_dir),
    .PORT_MODE(port_mode), .PRIORITY_ENABLE_IN(prio_in), .PRIORITY_ENABLE_OUT(prio_out),
    .INT_REQ_N(int_req_n), .INT_ENABLED(int_en));
  host_bus_model u_host (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n),
    .ce_n(ce_n), .port_sel(port_sel), .ctrl_sel(ctrl_sel), .io_req_n(io_req_n),
    .rd_n(rd_n), .fetch_n(fetch_n), .data_in(data_in));
  // clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // bounded wait for a request
  task automatic wait_req();
    for (int k = 0; k < 6 && int_req_n !== 1'b0; k++) @(negedge clock);
  endtask : wait_req
  // reset values
  task automatic t_reset();
    `CHK("mode", pio_ctl_pkg::MODE_RESET, port_mode)
    `CHK("dir", pio_ctl_pkg::DIR_RESET, port_dir)
    `CHK("out", 8'h00, port_out)
    `CHK("flags", 4'h7, {int_en, int_req_n, prio_out, data_oe_n})
  endtask : t_reset
  // every mode, ignored bits varied, then the direction word and a foreign write
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      u_host.wr(1'b0, 1'b1, {i[1:0], ~i[1:0], 4'hF});
      `CHK("mode", i[1:0], port_mode)
    end
    u_host.wr(1'b0, 1'b1, 8'h29); // host sends direction next
    `CHK("dir", 8'h29, port_dir)
    u_host.wr(1'b1, 1'b1, 8'h0F);
    `CHK("foreign", pio_ctl_pkg::MODE_BITCTL, port_mode)
    u_host.wr(1'b0, 1'b0, 8'h5A);
    `CHK("out", 8'h5A, port_out)
  endtask : t_modes
  // or logic on inputs, fetch blocking, acknowledge and return
  task automatic t_or_int();
    u_host.wr(1'b0, 1'b1, 8'h42);
    u_host.wr(1'b0, 1'b1, 8'hB7);
    `CHK("en early", 1'b0, int_en)
    u_host.wr(1'b0, 1'b1, 8'hD6); // host sends mask next
    `CHK("en mask", 1'b0, int_en)
    u_host.fetch(8'h00, 2);
    @(negedge clock);
    `CHK("en fetch", 1'b1, int_en)
    fork
      u_host.fetch(8'h00, 4);
      begin
        @(negedge clock);
        port_in = 8'h20;
        repeat (2) @(negedge clock);
        `CHK("req in fetch", 1'b1, int_req_n)
      end
    join
    wait_req();
    `CHK("req", 1'b0, int_req_n)
    u_host.ack(seen, v);
    `CHK("vec", 9'h142, {seen, v})
    `CHK("serv", 2'b01, {prio_out, int_req_n})
    u_host.fetch(pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_PREFIX, 2);
    u_host.fetch(pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_SECOND, 2);
    @(negedge clock);
    `CHK("ret", 1'b1, prio_out)
    repeat (3) @(negedge clock);
    `CHK("still true", 1'b1, int_req_n)
  endtask : t_or_int
  // enable command and no-mask enable skipping an acknowledge
  task automatic t_enable();
    port_in = 8'h00;
    u_host.wr(1'b0, 1'b1, 8'h03);
    `CHK("en off", 1'b0, int_en)
    u_host.wr(1'b0, 1'b1, 8'hA7);
    u_host.ack(seen, v);
    @(negedge clock);
    `CHK("en ack", 2'b00, {int_en, seen})
    u_host.fetch(8'h00, 2);
    @(negedge clock);
    `CHK("en fetch", 1'b1, int_en)
  endtask : t_enable
  // output register lines feed the logic, masked ones do not
  task automatic t_out_int();
    u_host.wr(1'b0, 1'b1, 8'hB7);
    u_host.wr(1'b0, 1'b1, 8'h56);
    u_host.fetch(8'h00, 2);
    u_host.wr(1'b0, 1'b0, 8'h02);
    repeat (3) @(negedge clock);
    `CHK("masked", 1'b1, int_req_n)
    u_host.wr(1'b0, 1'b0, 8'h82);
    wait_req();
    `CHK("out req", 1'b0, int_req_n)
  endtask : t_out_int
  // serve the output request, then and logic over two input lines
  task automatic t_and_int();
    u_host.ack(seen, v);
    `CHK("vec2", 9'h142, {seen, v})
    u_host.fetch(pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_PREFIX, 2);
    u_host.fetch(pio_ctl_pkg::RETURN_FROM_INTERRUPT_OPCODE_SECOND, 2);
    @(negedge clock);
    `CHK("ret2", 1'b1, prio_out)
    u_host.wr(1'b0, 1'b1, 8'hF7);
    u_host.wr(1'b0, 1'b1, 8'hDE);
    u_host.fetch(8'h00, 2);
    @(negedge clock);
    `CHK("en and", 1'b1, int_en)
    port_in = 8'h20;
    repeat (3) @(negedge clock);
    `CHK("and one", 1'b1, int_req_n)
    port_in = 8'h21;
    wait_req();
    `CHK("and all", 1'b0, int_req_n)
  endtask : t_and_int
  // reset, then the scenarios; a single device stays within the chain limit
  initial begin
    error_cnt = 0;
    check_count = 0;
    arst_n = 1'b0;
    prio_in = 1'b1;
    port_in = 8'h00;
    repeat (3) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    t_reset();
    t_modes();
    t_or_int();
    t_enable();
    t_out_int();
    t_and_int();
    give_verdict();
  end
  // watchdog
  initial begin
    #20000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
